/* design/etg_regs.svh */
`ifndef ETG_REGS_SVH
`define ETG_REGS_SVH
`define ETG_CSR_ADDR 12'h7a9
`define ETG_TEST_BIT 31
`define ETG_IDLE_VALUE 32'h00000001
`define ETG_HEALTH_WINDOW 10'h3ff
`define ETG_REP_CUTOFF 6'h20
`define ETG_FATAL_ALARMS 4'h4
`define ETG_SELFTEST_CYCLES 8'h40
`define ETG_ZERO_CYCLES 8'h08
`define ETG_POOL_LAST 4'hf
`endif

/* design/etg_pkg.sv */
package etg_pkg;
    typedef enum logic [3:0] {
        ETG_SELFTEST = 4'h1,
        ETG_WAIT = 4'h2,
        ETG_READY = 4'h4,
        ETG_FAULT = 4'h8
    } etg_seed_e;
    typedef enum logic [2:0] {
        ETG_P_IDLE = 3'h1,
        ETG_P_ZERO = 3'h2,
        ETG_P_TEST = 3'h4
    } etg_phase_e;
endpackage : etg_pkg

/* design/entropy_test_mode_gate.sv */
// Functional notes
// - Test register reachable only in machine mode
// - Bit 31 enables test, alters seed
// - Test on: self-test state unless fatal
// - Test on: no waiting, ready, entropy
// - Leaving test: zeroize then self-test
// - Without test interface: read zero, drop writes
// - Idle test register reads fixed constant
// - Other bits vendor-defined, identify via ids
// - Raw test samples never reach seed data output
// - Reset clears all health-test counters
// - Cutoff gives self-test or fatal state
`timescale 1ns/1ps
`include "etg_regs.svh"
module entropy_test_mode_gate import etg_pkg::*; #(
    parameter bit HAS_TEST = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic csrRead,
    input wire logic csrWrite,
    input wire logic [11:0] csrAddr,
    input wire logic [31:0] csrWdata,
    input wire logic machineMode,
    input wire logic noiseBit,
    input wire logic seedTake,
    output logic [31:0] csrRdata_q,
    output logic csrHit_q,
    output logic [3:0] seedState_q,
    output logic [15:0] seedData_q
);
    // ****************************************************
    // Register access and test bit
    // ****************************************************
    logic nsMeta_q;
    logic nsSync_q;
    logic testEn_q;
    logic [30:0] rawSamples_q;
    logic hit;
    etg_seed_e state_q;
    etg_phase_e phase_q;
    logic [7:0] phaseCnt_q;
    logic [9:0] winCnt_q;
    logic [5:0] repCnt_q;
    logic [3:0] alarmCnt_q;
    logic [3:0] bitCnt_q;
    logic [15:0] pool_q;
    logic lastBit_q;
    logic cutoff;
    logic zeroDone;
    logic testDone;
    logic poolFull;

    assign hit = (csrAddr == `ETG_CSR_ADDR) && machineMode;

    // ****************************************************
    // Noise synchroniser
    // ****************************************************
    always_ff @(posedge mclk) begin
        nsMeta_q <= noiseBit;
        nsSync_q <= nsMeta_q;
    end

    // ****************************************************
    // Test enable and read data
    // ****************************************************
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            testEn_q <= 1'b0;
        end else if (HAS_TEST && csrWrite && hit) begin
            testEn_q <= csrWdata[`ETG_TEST_BIT];
        end
    end

    // Vendor bits carry a raw sample shift register, live only in test
    always_ff @(posedge mclk) begin
        if (!rst_n || !testEn_q) begin
            rawSamples_q <= '0;
        end else begin
            rawSamples_q <= {rawSamples_q[29:0], nsSync_q};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            csrRdata_q <= '0;
            csrHit_q <= 1'b0;
        end else begin
            csrHit_q <= (csrRead || csrWrite) && hit;
            if (!(csrRead && hit) || !HAS_TEST) begin
                csrRdata_q <= '0;
            end else if (testEn_q) begin
                csrRdata_q <= {1'b1, rawSamples_q};
            end else begin
                csrRdata_q <= `ETG_IDLE_VALUE;
            end
        end
    end

    // ****************************************************
    // Health tests
    // ****************************************************
    assign cutoff = (repCnt_q == `ETG_REP_CUTOFF);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            winCnt_q <= '0;
            repCnt_q <= '0;
            lastBit_q <= 1'b0;
        end else begin
            winCnt_q <= (winCnt_q == `ETG_HEALTH_WINDOW) ? '0 : winCnt_q + 10'h1;
            lastBit_q <= nsSync_q;
            if (nsSync_q != lastBit_q || cutoff || winCnt_q == `ETG_HEALTH_WINDOW) begin
                repCnt_q <= '0;
            end else begin
                repCnt_q <= repCnt_q + 6'h1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarmCnt_q <= '0;
        end else if (cutoff && alarmCnt_q != `ETG_FATAL_ALARMS) begin
            alarmCnt_q <= alarmCnt_q + 4'h1;
        end
    end

    // ****************************************************
    // Seed state machine
    // ****************************************************
    assign zeroDone = (phaseCnt_q == `ETG_ZERO_CYCLES);
    assign testDone = (phaseCnt_q == `ETG_SELFTEST_CYCLES);
    assign poolFull = (bitCnt_q == `ETG_POOL_LAST);

    // Zeroize and self-test run after reset and again on every test exit
    // Zeroize holds at its start while test is on, so the whole
    // sequence always follows the clearing of the test bit
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            phase_q <= ETG_P_ZERO;
            phaseCnt_q <= '0;
        end else begin
            case (phase_q)
                ETG_P_IDLE: begin
                    if (testEn_q) begin
                        phase_q <= ETG_P_ZERO;
                        phaseCnt_q <= '0;
                    end
                end
                ETG_P_ZERO: begin
                    if (testEn_q) begin
                        phaseCnt_q <= '0;
                    end else if (zeroDone) begin
                        phase_q <= ETG_P_TEST;
                        phaseCnt_q <= '0;
                    end else begin
                        phaseCnt_q <= phaseCnt_q + 8'h1;
                    end
                end
                ETG_P_TEST: begin
                    if (testEn_q) begin
                        phase_q <= ETG_P_ZERO;
                        phaseCnt_q <= '0;
                    end else if (testDone) begin
                        phase_q <= ETG_P_IDLE;
                    end else begin
                        phaseCnt_q <= phaseCnt_q + 8'h1;
                    end
                end
                default: phase_q <= ETG_P_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= ETG_SELFTEST;
            bitCnt_q <= '0;
            pool_q <= '0;
        end else if (state_q == ETG_FAULT || alarmCnt_q == `ETG_FATAL_ALARMS) begin
            state_q <= ETG_FAULT;
            pool_q <= '0;
        end else if (testEn_q || phase_q != ETG_P_IDLE || cutoff) begin
            state_q <= ETG_SELFTEST;
            pool_q <= '0;
            bitCnt_q <= '0;
        end else begin
            case (state_q)
                ETG_READY: begin
                    if (seedTake) begin
                        state_q <= ETG_WAIT;
                        bitCnt_q <= '0;
                    end
                end
                ETG_SELFTEST, ETG_WAIT: begin
                    state_q <= ETG_WAIT;
                    pool_q <= {pool_q[14:0], nsSync_q};
                    bitCnt_q <= bitCnt_q + 4'h1;
                    if (poolFull) begin
                        state_q <= ETG_READY;
                    end
                end
                default: state_q <= ETG_SELFTEST;
            endcase
        end
    end

    // ****************************************************
    // Seed outputs
    // ****************************************************
    // Data leaves only in the ready state; nothing else can touch it
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            seedState_q <= ETG_SELFTEST;
            seedData_q <= '0;
        end else begin
            seedState_q <= state_q;
            seedData_q <= (state_q == ETG_READY) ? pool_q : '0;
        end
    end
endmodule : entropy_test_mode_gate

/* testbench/etg_monitor.sv */
`timescale 1ns/1ps
`include "etg_regs.svh"
module etg_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic csrRead,
    input wire logic csrWrite,
    input wire logic [11:0] csrAddr,
    input wire logic [31:0] csrWdata,
    input wire logic machineMode,
    input wire logic [31:0] csrRdata_q,
    input wire logic csrHit_q,
    input wire logic [3:0] seedState_q,
    input wire logic [15:0] seedData_q
);
    logic testEn_q;
    logic [1:0] testAge_q;
    wire logic hit = machineMode && csrAddr == `ETG_CSR_ADDR;
    // Two cycles of test before the registered seed state must show it
    wire logic oldTest = testAge_q == 2'h2;
    always_ff @(posedge mclk) begin
        if (!rst_n)
            testEn_q <= 1'b0;
        else if (csrWrite && hit)
            testEn_q <= csrWdata[`ETG_TEST_BIT];
    end
    always_ff @(posedge mclk) begin
        if (!rst_n || !testEn_q)
            testAge_q <= 2'h0;
        else if (testAge_q != 2'h2)
            testAge_q <= testAge_q + 2'h1;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_test_parks: assert property (oldTest |-> seedState_q inside {4'h1, 4'h8})
        else $error("seed left self-test in test mode");
    chk_test_silent: assert property (oldTest |-> seedData_q == 16'h0)
        else $error("seed data in test mode");
    chk_data_gated: assert property (seedData_q != 16'h0 |-> seedState_q == 4'h4)
        else $error("seed data outside ready");
    chk_user_refused: assert property ((csrRead || csrWrite) && !machineMode |=>
        !csrHit_q && csrRdata_q == 32'h0) else $error("user access seen");
    chk_idle_read: assert property (csrRead && !csrWrite && hit && !testEn_q |=>
        csrRdata_q == `ETG_IDLE_VALUE) else $error("idle read wrong");
    chk_test_read: assert property (csrRead && !csrWrite && hit && testEn_q |=>
        csrRdata_q[31]) else $error("test bit not read back");
    chk_hit_flag: assert property ((csrRead || csrWrite) && hit |=> csrHit_q)
        else $error("hit missing");
    chk_leave_test: assert property ($fell(testEn_q) |->
        (seedState_q inside {4'h1, 4'h8})[*8]) else $error("left test too soon");
    chk_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
        seedState_q == 4'h1 && seedData_q == 16'h0) else $error("reset state wrong");
    cover property (csrRead && hit && testEn_q);
    cover property ($fell(testEn_q));
    cover property (seedState_q == 4'h4);
    cover property (seedState_q == 4'h8);
endmodule : etg_monitor
bind entropy_test_mode_gate etg_monitor etg_monitor_inst (.mclk(mclk), .rst_n(rst_n),
    .csrRead(csrRead), .csrWrite(csrWrite), .csrAddr(csrAddr), .csrWdata(csrWdata),
    .machineMode(machineMode), .csrRdata_q(csrRdata_q), .csrHit_q(csrHit_q),
    .seedState_q(seedState_q), .seedData_q(seedData_q));

/* testbench/etg_noise_model.sv */
`timescale 1ns/1ps
module etg_noise_model (
    input wire logic mclk,
    input wire logic stuck,
    output logic noiseBit
);
    logic [4:0] cnt_q = 5'h0;
    // Stuck level stands for a failed source
    assign noiseBit = stuck | (cnt_q[0] ^ cnt_q[3]);
    always @(posedge mclk) begin
        cnt_q <= cnt_q + 5'h1;
    end
endmodule : etg_noise_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`include "etg_regs.svh"
module tb_top import etg_pkg::*;;
    logic mclk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, mm = 1'b0, stuck = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic noise, hit;
    logic take = 1'b0;
    logic [3:0] state;
    logic [15:0] sdata;
    int errors = 0, samples_checked = 0;
    initial forever #2.5 mclk = ~mclk;
    etg_noise_model etg_noise_model_inst (.mclk(mclk), .stuck(stuck), .noiseBit(noise));
    entropy_test_mode_gate entropy_test_mode_gate_inst (.mclk(mclk), .rst_n(rst_n),
        .csrRead(rd), .csrWrite(wr), .csrAddr(addr), .csrWdata(wdata), .machineMode(mm),
        .noiseBit(noise), .seedTake(take), .csrRdata_q(rdata), .csrHit_q(hit),
        .seedState_q(state), .seedData_q(sdata));
    task automatic cmpW(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpW
    task automatic cmpS(input logic [3:0] got, input etg_seed_e exp);
        cmpW({28'h0, got}, {28'h0, exp});
    endtask : cmpS
    task automatic acc(input logic w, input logic m, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        rd <= !w;
        wr <= w;
        mm <= m;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
    endtask : acc
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic print_verdict;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict
    initial begin
        #15000;
        errors++;
        print_verdict();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        cmpS(state, ETG_SELFTEST);
        acc(1'b0, 1'b1, `ETG_CSR_ADDR, 32'h0);
        cmpW(rdata, `ETG_IDLE_VALUE);
        cmpW({31'h0, hit}, 32'h1);
        acc(1'b0, 1'b0, `ETG_CSR_ADDR, 32'h0);
        cmpW(rdata, 32'h0);
        acc(1'b0, 1'b1, 12'h7aa, 32'h0);
        cmpW({31'h0, hit}, 32'h0);
        cyc(120);
        cmpS(state, ETG_READY);
        acc(1'b1, 1'b1, `ETG_CSR_ADDR, 32'h80000000);
        cyc(3);
        cmpS(state, ETG_SELFTEST);
        acc(1'b1, 1'b0, `ETG_CSR_ADDR, 32'h0);
        cyc(120);
        cmpW({12'h0, state, sdata}, {12'h0, ETG_SELFTEST, 16'h0});
        acc(1'b0, 1'b1, `ETG_CSR_ADDR, 32'h0);
        cmpW({31'h0, rdata[31]}, 32'h1);
        cmpW({31'h0, |rdata[30:0]}, 32'h1);
        acc(1'b1, 1'b1, `ETG_CSR_ADDR, 32'h0);
        cyc(40);
        cmpS(state, ETG_SELFTEST);
        cyc(60);
        cmpS(state, ETG_READY);
        cmpW({31'h0, |sdata}, 32'h1);
        @(posedge mclk);
        take <= 1'b1;
        @(posedge mclk);
        take <= 1'b0;
        stuck <= 1'b1;
        cyc(1);
        cmpS(state, ETG_WAIT);
        for (int i = 0; i < 80 && state !== ETG_SELFTEST; i++) cyc(1);
        cmpS(state, ETG_SELFTEST);
        cyc(150);
        cmpS(state, ETG_FAULT);
        acc(1'b1, 1'b1, `ETG_CSR_ADDR, 32'h80000000);
        cyc(3);
        cmpS(state, ETG_FAULT);
        print_verdict();
    end
endmodule : tb_top
